// ===== fanout_pkg.sv
// Constants for the automatic reference fanout switch.
// Assumes one 25 MHz clock from the crystal; the reference is sampled.
// Summary of operation
// - Status pin goes high when the reference stops toggling.
// - Status pin goes low once a valid reference returns.
// - While reset input is low, a returning reference is fanned out.
// - Reference lost in automatic mode falls back to the bank divider.
// - Reference returning after fallback is routed back automatically.
// - Per-bank mode setting; fanout mode joins automatic switching.
// - While reset input is low, status high selects divider; status low selects the reference.
// - While reset input is high, choice re-evaluated only on its rising edge; if high since reset, status keeps driving it.
package fanout_pkg;
	// Reference idle time before loss is declared, in ns
	localparam int LOS_TIME_NS = 400;
	localparam int CLK_PERIOD_NS = 40;
	// Longest time rounds down, at least one cycle
	localparam int LOS_CYCLES = (LOS_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(LOS_TIME_NS / CLK_PERIOD_NS);
	// Edges needed on the reference before it counts as valid
	localparam int VALID_EDGES = 4;
	localparam int BANK_COUNT = 7;
	// Reset values
	localparam logic LOS_RESET = 1'b1;
	localparam logic SEL_RESET = 1'b0;
	// Per-bank fanout mode setting
	typedef enum logic {MODE_NORMAL, MODE_FANOUT} bank_mode_t;
endpackage

// ===== glitchless_mux.sv
// Glitch-free two-input clock selector for one output bank.
// Assumes both inputs are sampled in the mclk domain and change slowly.
`timescale 1ns/1ps
module glitchless_mux
	import fanout_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sel_ref,
	input wire logic div_clk,
	input wire logic ref_clk,
	output logic out_clk
);
	logic div_on_reg;
	logic ref_on_reg;
	logic out_next;

	// Break-before-make: one side is released only while low
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			div_on_reg <= 1'b1;
			ref_on_reg <= 1'b0;
		end
		else
		begin
			if (!sel_ref && !ref_on_reg && !div_clk)
				div_on_reg <= 1'b1;
			else if (sel_ref && !div_clk)
				div_on_reg <= 1'b0;
			if (sel_ref && !div_on_reg && !ref_clk)
				ref_on_reg <= 1'b1;
			else if (!sel_ref && !ref_clk)
				ref_on_reg <= 1'b0;
		end
	end

	// Combine gated sources
	always_comb
	begin
		out_next = (div_on_reg & div_clk) | (ref_on_reg & ref_clk);
	end

	// Registered output
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			out_clk <= 1'b0;
		else
			out_clk <= out_next;
	end

	no_overlap_a: assert property (@(posedge mclk) disable iff (rst)
		!(div_on_reg && ref_on_reg))
		else $error("both sources enabled");

	// Each side is gated on or off only while its clock is low
	div_release_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(div_on_reg) |-> !$past(div_clk))
		else $error("divider cut while high");
	div_engage_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(div_on_reg) |-> !$past(div_clk))
		else $error("divider joined while high");
	ref_release_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(ref_on_reg) |-> !$past(ref_clk))
		else $error("reference cut while high");
	ref_engage_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(ref_on_reg) |-> !$past(ref_clk))
		else $error("reference joined while high");
endmodule // glitchless_mux

// ===== auto_ref_fanout_switch.sv
// Top of the automatic reference fanout switch with per-bank selectors.
// Assumes reference and reset input are synchronous to mclk.
`timescale 1ns/1ps
module auto_ref_fanout_switch
	import fanout_pkg::*;
#(
	parameter int BANKS = BANK_COUNT
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ref_input_zero,
	input wire logic control_pin_one,
	input wire logic [BANKS-1:0] bank_fanout_mode,
	input wire logic [BANKS-1:0] div_clk,
	output logic status_pin_zero,
	output logic [BANKS-1:0] bank_out_clk,
	output logic ref_selected
);
	localparam int CW = $clog2(LOS_CYCLES + 1);
	localparam int EW = $clog2(VALID_EDGES + 1);
	logic ref_prev_reg;
	logic ctl_prev_reg;
	logic [CW-1:0] idle_reg;
	logic [EW-1:0] edges_reg;
	logic los_reg;
	logic latched_reg;
	logic sel_reg;
	logic ref_edge;
	logic ctl_rise;
	logic ref_gated;

	assign ref_edge = ref_input_zero & ~ref_prev_reg;

	// Dead reference held low so a bank stuck on a high level can release
	assign ref_gated = ref_input_zero & ~los_reg;
	assign ctl_rise = control_pin_one & ~ctl_prev_reg;

	// Edge history of the sampled pins
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ref_prev_reg <= 1'b0;
			ctl_prev_reg <= 1'b1;
		end
		else
		begin
			ref_prev_reg <= ref_input_zero;
			ctl_prev_reg <= control_pin_one;
		end
	end

	// Idle counter: cleared on each rising reference edge
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			idle_reg <= '0;
		else if (ref_edge)
			idle_reg <= '0;
		else if (idle_reg != CW'(LOS_CYCLES))
			idle_reg <= idle_reg + 1'b1;
	end

	// Valid-edge counter for clock return
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			edges_reg <= '0;
		else if (idle_reg == CW'(LOS_CYCLES))
			edges_reg <= '0;
		else if (ref_edge && edges_reg != EW'(VALID_EDGES))
			edges_reg <= edges_reg + 1'b1;
	end

	// Loss-of-signal flag
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			los_reg <= LOS_RESET;
		else if (idle_reg == CW'(LOS_CYCLES))
			los_reg <= 1'b1;
		else if (edges_reg == EW'(VALID_EDGES))
			los_reg <= 1'b0;
	end

	// Latch: automatic while input low, frozen after a rising edge
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			latched_reg <= 1'b0;
		else if (ctl_rise)
			latched_reg <= 1'b1;
		else if (!control_pin_one)
			latched_reg <= 1'b0;
	end

	// Source choice: follows loss status unless latched
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sel_reg <= SEL_RESET;
		else if (!latched_reg || ctl_rise)
			sel_reg <= ~los_reg;
	end

	// Status and selection outputs
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			status_pin_zero <= LOS_RESET;
			ref_selected <= SEL_RESET;
		end
		else
		begin
			status_pin_zero <= los_reg;
			ref_selected <= sel_reg;
		end
	end

	// One selector per bank; only fanout-mode banks follow the choice
	genvar b;
	generate
		for (b = 0; b < BANKS; b++)
		begin : g_bank
			logic bank_sel;
			assign bank_sel = sel_reg &
				(bank_fanout_mode[b] == MODE_FANOUT);
			glitchless_mux u_mux (
				.mclk(mclk),
				.rst(rst),
				.sel_ref(bank_sel),
				.div_clk(div_clk[b]),
				.ref_clk(ref_gated),
				.out_clk(bank_out_clk[b])
			);
		end
	endgenerate

	los_set_a: assert property (@(posedge mclk) disable iff (rst)
		(idle_reg == CW'(LOS_CYCLES)) |=> los_reg)
		else $error("loss not flagged");
	los_clear_a: assert property (@(posedge mclk) disable iff (rst)
		(idle_reg != CW'(LOS_CYCLES) && edges_reg == EW'(VALID_EDGES))
		|=> !los_reg)
		else $error("loss not cleared");
	status_pin_a: assert property (@(posedge mclk) disable iff (rst)
		##1 status_pin_zero == $past(los_reg))
		else $error("status pin lags");
	auto_follow_a: assert property (@(posedge mclk) disable iff (rst)
		(!latched_reg) |=> sel_reg == !$past(los_reg))
		else $error("auto mode not following");
	fallback_div_a: assert property (@(posedge mclk) disable iff (rst)
		(!latched_reg && los_reg) |=> !sel_reg)
		else $error("no fallback to divider");
	return_ref_a: assert property (@(posedge mclk) disable iff (rst)
		(!latched_reg && !los_reg) |=> sel_reg)
		else $error("no return to reference");
	latch_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(latched_reg && !ctl_rise) |=> $stable(sel_reg))
		else $error("choice changed while latched");
	rise_eval_a: assert property (@(posedge mclk) disable iff (rst)
		ctl_rise |=> sel_reg == !$past(los_reg))
		else $error("rising edge did not re-evaluate");
	normal_bank_a: assert property (@(posedge mclk) disable iff (rst)
		(bank_fanout_mode[0] == MODE_NORMAL) |-> !g_bank[0].bank_sel)
		else $error("normal bank joined switching");

	// Fanout-mode bank 6 follows the common choice
	fanout_join_a: assert property (@(posedge mclk) disable iff (rst)
		(bank_fanout_mode[6] == MODE_FANOUT) |->
		g_bank[6].bank_sel == sel_reg)
		else $error("fanout bank not switching");

	// Idle counter behaviour
	idle_clear_a: assert property (@(posedge mclk) disable iff (rst)
		ref_edge |=> idle_reg == '0)
		else $error("idle count not cleared");
	idle_count_a: assert property (@(posedge mclk) disable iff (rst)
		(!ref_edge && idle_reg != CW'(LOS_CYCLES))
		|=> idle_reg == CW'($past(idle_reg) + 1'b1))
		else $error("idle count stalled");
	idle_sat_a: assert property (@(posedge mclk) disable iff (rst)
		(!ref_edge && idle_reg == CW'(LOS_CYCLES))
		|=> idle_reg == CW'(LOS_CYCLES))
		else $error("idle count wrapped");

	// Valid-edge counter and loss-flag hold behaviour
	edges_clear_a: assert property (@(posedge mclk) disable iff (rst)
		(idle_reg == CW'(LOS_CYCLES)) |=> edges_reg == '0)
		else $error("edge count kept while idle");
	edges_count_a: assert property (@(posedge mclk) disable iff (rst)
		(ref_edge && idle_reg != CW'(LOS_CYCLES) &&
		edges_reg != EW'(VALID_EDGES))
		|=> edges_reg == EW'($past(edges_reg) + 1'b1))
		else $error("edge not counted");
	los_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(idle_reg != CW'(LOS_CYCLES) && edges_reg != EW'(VALID_EDGES))
		|=> $stable(los_reg))
		else $error("loss flag moved without cause");

	// Reset-input latch
	latch_set_a: assert property (@(posedge mclk) disable iff (rst)
		ctl_rise |=> latched_reg)
		else $error("rising edge not latched");
	latch_clear_a: assert property (@(posedge mclk) disable iff (rst)
		(!control_pin_one && !ctl_rise) |=> !latched_reg)
		else $error("latch kept while input low");
	rise_detect_a: assert property (@(posedge mclk) disable iff (rst)
		ctl_rise |-> !$past(control_pin_one))
		else $error("rise without low level before");

	// Outputs and reference gating
	ref_sel_out_a: assert property (@(posedge mclk) disable iff (rst)
		ref_selected == $past(sel_reg))
		else $error("selection output lags");
	gate_low_a: assert property (@(posedge mclk) disable iff (rst)
		los_reg |-> !ref_gated)
		else $error("dead reference reaches banks");
endmodule // auto_ref_fanout_switch

// ===== ref_source.sv
// Far-side model: reference clock source and reset-request driver.
// Assumes the bench commands run and request on mclk edges.
`timescale 1ns/1ps
module ref_source
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic req_high,
	output logic ref_clk,
	output logic ctl_pin
);
	// Toggle on two cycles of every four, stopped clock holds its level
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			ref_clk <= 1'b0;
		else if (run && $time % 160 < 80)
			ref_clk <= ~ref_clk;
	end
	// Request pin follows the command
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			ctl_pin <= 1'b0;
		else
			ctl_pin <= req_high;
	end
endmodule // ref_source

// ===== auto_ref_fanout_switch_tb.sv
// Self-checking bench for the automatic reference fanout switch.
// Assumes a 25 MHz mclk and the far-side model in ref_source.
`timescale 1ns/1ps
module auto_ref_fanout_switch_tb
	import fanout_pkg::*;
;
	logic mclk, rst, run, req, ref_clk, ctl, stat, sel;
	logic [BANK_COUNT-1:0] mode, div, outc;
	int err_count, comparisons;
	logic exp_sel, exp_los;
	logic [BANK_COUNT-1:0] div_seed;
	auto_ref_fanout_switch i_auto_ref_fanout_switch (.mclk(mclk), .rst(rst),
		.ref_input_zero(ref_clk), .control_pin_one(ctl),
		.bank_fanout_mode(mode), .div_clk(div), .status_pin_zero(stat),
		.bank_out_clk(outc), .ref_selected(sel));
	ref_source i_ref_source (.mclk(mclk), .rst(rst), .run(run),
		.req_high(req), .ref_clk(ref_clk), .ctl_pin(ctl));
	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Divider clocks: random phase per bank, toggled every other cycle
	always @(posedge mclk)
		if (rst)
			div <= div_seed;
		else if ($time % 80 < 40)
			div <= ~div;
	task check(input logic [BANK_COUNT-1:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Model of each bank: levels seen at one edge show one cycle later
	task chk_banks(input int n);
		logic [BANK_COUNT-1:0] e, f;
		logic r;
		f = mode & {BANK_COUNT{exp_sel}};
		r = ref_clk & ~exp_los;
		e = (f & {BANK_COUNT{r}}) | (~f & div);
		repeat (n)
		begin
			@(negedge mclk);
			check(outc, e);
			f = mode & {BANK_COUNT{exp_sel}};
			r = ref_clk & ~exp_los;
			e = (f & {BANK_COUNT{r}}) | (~f & div);
		end
	endtask
	// Settle, compare at mid-cycle, end on a rising edge
	task step(input int n, input logic los, input logic s);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
		check(BANK_COUNT'(stat), BANK_COUNT'(los));
		check(BANK_COUNT'(sel), BANK_COUNT'(s));
		exp_sel = s;
		exp_los = los;
		chk_banks(6);
		@(posedge mclk);
	endtask
	task finish_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_count++;
		finish_test();
	end
	initial
	begin
		void'($urandom(84));
		div_seed = BANK_COUNT'($urandom);
		rst = 1'b1;
		run = 1'b1;
		req = 1'b0;
		mode = '0;
		exp_sel = 1'b0;
		exp_los = 1'b1;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		mode <= BANK_COUNT'($urandom) | BANK_COUNT'(7'h50);
		step(36, 1'b0, 1'b1);
		run <= 1'b0;
		step(24, 1'b1, 1'b0);
		run <= 1'b1;
		step(36, 1'b0, 1'b1);
		req <= 1'b1;
		repeat (4) @(posedge mclk);
		run <= 1'b0;
		step(24, 1'b1, 1'b1);
		req <= 1'b0;
		step(12, 1'b1, 1'b0);
		finish_test();
	end
endmodule // auto_ref_fanout_switch_tb
